// ---- accel_cfg.svh ----
// Behaviour
// RULE_01 - filter code 8/9/A: 4x, 2x, normal
// RULE_02 - rate codes 5..C give 12.5..1600 Hz
// RULE_03 - range code 0..3 gives 3/6/12/24 g
// RULE_04 - host keeps the must-be-one bits set
// RULE_05 - fifo rate divided by two^downsampling field
// RULE_06 - watermark flag when bytes reach threshold
// RULE_07 - mode bit: 0 stream, 1 fifo
// RULE_08 - sample frames stored only when enabled
// RULE_09 - pin one events stored when enabled
// RULE_10 - pin two events stored when enabled
// RULE_11 - reset: normal filter, 100 Hz, 6 g
// RULE_12 - 14-bit byte counter, whole frames only
// RULE_13 - bad filter or rate reports error one
// RULE_14 - stream drops oldest, fifo mode drops newest
`ifndef ACCEL_CFG_SVH
`define ACCEL_CFG_SVH

`define ADDR_CHIP_ID 7'h00
`define ADDR_ERR 7'h02
`define ADDR_FIFO_LEN0 7'h24
`define ADDR_FIFO_LEN1 7'h25
`define ADDR_ACCEL_FILTER_RATE_CONFIG 7'h40
`define ADDR_ACC_RANGE 7'h41
`define ADDR_DOWNS 7'h45
`define ADDR_WTM0 7'h46
`define ADDR_WTM1 7'h47
`define ADDR_CFG0 7'h48
`define ADDR_CFG1 7'h49
`define ADDR_CMD 7'h7e

`define RST_ACCEL_FILTER_RATE_CONFIG 8'ha8
`define RST_RANGE 2'h1
`define RST_DOWNS 8'h80
`define RST_WTM 13'h0000
`define RST_CFG0 2'h2
`define RST_CFG1 5'h04

`define FILT_FOURFOLD_OVERSAMPLING 4'h8
`define FILT_TWOFOLD_OVERSAMPLING 4'h9
`define FILT_NORMAL 4'ha
`define ODR_MIN 4'h5
`define ODR_MAX 4'hc
`define ERR_CONFIG 3'h1
`define CMD_SOFTRESET 8'hb6
`define CMD_FLUSH 8'hb0

`define DOWNS_RES_BIT 7
`define CFG0_MODE_BIT 0
`define CFG1_ACC_BIT 4
`define CFG1_PIN1_BIT 1
`define CFG1_PIN2_BIT 0

`define ACC_FRAME_BYTES 14'h0007
`define EVT_FRAME_BYTES 14'h0002
`define FIFO_DEPTH 8

`define CLK_PERIOD_NS 50
`define BASE_PERIOD_NS 625000
`define SOFT_RESET_NS 1000000

`endif

// ---- accel_pkg.sv ----
package accel_pkg;
	typedef enum logic [1:0] {
		KIND_ACCEL = 2'h0,
		KIND_PIN_ONE = 2'h1,
		KIND_PIN_TWO = 2'h2
	} frame_kind_t;

	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] z;
	} sample_t;

	typedef struct packed {
		frame_kind_t kind;
		sample_t data;
	} frame_t;

	typedef enum logic [1:0] {
		SR_IDLE = 2'b01,
		SR_WAIT = 2'b10
	} soft_reset_state_t;
endpackage

// ---- frame_fifo.sv ----
`timescale 1ns/1ps
module frame_fifo #(
	parameter int WIDTH = 50,
	parameter int DEPTH = 8
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_clear,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data,
	output logic o_full
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign o_full = (cnt_q == (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	// a full buffer still takes a word in the cycle it gives one away
	assign o_in_ready = !o_full || i_out_ready;
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_out_data = mem_q[rd_q];

	always_ff @(posedge i_core_clk)
	begin
		if (push)
			mem_q[wr_q] <= i_in_data;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst || i_clear)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wr_q <= push ? AW'(wr_q + 1'b1) : wr_q;
			rd_q <= pop ? AW'(rd_q + 1'b1) : rd_q;
			cnt_q <= (AW+1)'(cnt_q + push - pop);
		end
	end
endmodule

// ---- accel_config_fifo_setup_regs.sv ----
`timescale 1ns/1ps
`include "accel_cfg.svh"
module accel_config_fifo_setup_regs
	import accel_pkg::*;
#(
	parameter int BASE_TICK_CYCLES = `BASE_PERIOD_NS / `CLK_PERIOD_NS,
	parameter int SOFT_RESET_CYCLES = `SOFT_RESET_NS / `CLK_PERIOD_NS,
	parameter logic [7:0] CHIP_ID = 8'h5a
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [6:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	input wire sample_t i_sample,
	input wire logic i_event_pin_one,
	input wire logic i_event_pin_two,
	output logic o_sample_tick,
	output logic o_frame_valid,
	input wire logic i_frame_ready,
	output frame_t o_frame,
	output logic [13:0] o_fifo_bytes,
	output logic o_fifo_watermark,
	output logic o_fifo_full,
	output logic o_config_error,
	output logic o_fourfold_oversampling,
	output logic o_twofold_oversampling,
	output logic [4:0] o_full_scale_g
);
	// chip id value is arbitrary

	function automatic logic [13:0] frame_bytes(input frame_kind_t kind);
		frame_bytes = (kind == KIND_ACCEL) ? `ACC_FRAME_BYTES : `EVT_FRAME_BYTES;
	endfunction

	function automatic logic low_bits_clear(input logic [14:0] cnt, input logic [3:0] n);
		logic [14:0] mask;
		mask = 15'((16'h0001 << n) - 16'h0001);
		low_bits_clear = ((cnt & mask) == 15'h0000);
	endfunction

	logic [7:0] accel_filter_rate_config_q;
	logic [1:0] range_q;
	logic [7:0] downs_q;
	logic [12:0] wtm_q;
	logic [1:0] cfg0_q;
	logic [4:0] cfg1_q;
	logic [2:0] err_q;
	logic [13:0] bytes_q;
	logic [13:0] bytes_d;
	logic [13:0] base_cnt_q;
	logic [14:0] rate_cnt_q;
	logic [1:0] pin_prev_q;
	logic [1:0] evt_pend_q;
	logic [1:0] evt_pend_d;
	logic acc_pend_q;
	logic acc_pend_d;
	sample_t sample_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic tick_q;
	logic four_q;
	logic two_q;
	logic [4:0] scale_q;
	logic [4:0] scale_d;
	soft_reset_state_t sr_state_q;
	soft_reset_state_t sr_state_d;
	logic [14:0] sr_cnt_q;

	logic rst_all;
	logic soft_fire;
	logic wr_conf;
	logic wr_range;
	logic wr_downs;
	logic wr_wtm0;
	logic wr_wtm1;
	logic wr_cfg0;
	logic wr_cfg1;
	logic wr_cmd;
	logic flush;
	logic [3:0] filter_code;
	logic [3:0] odr_code;
	logic [2:0] downs_code;
	logic filter_ok;
	logic odr_ok;
	logic cfg_ok;
	logic [3:0] odr_shift;
	logic [3:0] fifo_shift;
	logic base_tick;
	logic odr_tick;
	logic fifo_tick;
	logic stream_mode;
	logic acc_en;
	logic [1:0] pin_en;
	logic [1:0] pins;
	logic [1:0] pin_rise;
	frame_t push_frame;
	logic push_valid;
	logic push_ready;
	logic push_fire;
	logic fifo_full;
	logic pop_ready;
	logic pop_valid;
	logic pop_fire;
	logic drop_oldest;
	frame_t pop_frame;

	assign rst_all = i_rst || soft_fire;

	// write decode
	assign wr_conf = i_reg_wr && (i_reg_addr == `ADDR_ACCEL_FILTER_RATE_CONFIG);
	assign wr_range = i_reg_wr && (i_reg_addr == `ADDR_ACC_RANGE);
	assign wr_downs = i_reg_wr && (i_reg_addr == `ADDR_DOWNS);
	assign wr_wtm0 = i_reg_wr && (i_reg_addr == `ADDR_WTM0);
	assign wr_wtm1 = i_reg_wr && (i_reg_addr == `ADDR_WTM1);
	assign wr_cfg0 = i_reg_wr && (i_reg_addr == `ADDR_CFG0);
	assign wr_cfg1 = i_reg_wr && (i_reg_addr == `ADDR_CFG1);
	assign wr_cmd = i_reg_wr && (i_reg_addr == `ADDR_CMD);
	assign flush = wr_cmd && (i_reg_wdata == `CMD_FLUSH);

	// configuration registers; must-be-one bits are stored as written
	always_ff @(posedge i_core_clk)
	begin
		if (rst_all)
		begin
			accel_filter_rate_config_q <= `RST_ACCEL_FILTER_RATE_CONFIG; // see RULE_11
			range_q <= `RST_RANGE; // see RULE_11
			downs_q <= `RST_DOWNS;
			wtm_q <= `RST_WTM;
			cfg0_q <= `RST_CFG0;
			cfg1_q <= `RST_CFG1;
		end
		else
		begin
			accel_filter_rate_config_q <= wr_conf ? i_reg_wdata : accel_filter_rate_config_q;
			range_q <= wr_range ? i_reg_wdata[1:0] : range_q;
			downs_q <= wr_downs ? {i_reg_wdata[7:4], 4'h0} : downs_q; // see RULE_04
			wtm_q <= wr_wtm0 ? {wtm_q[12:8], i_reg_wdata} :
				wr_wtm1 ? {i_reg_wdata[4:0], wtm_q[7:0]} : wtm_q;
			cfg0_q <= wr_cfg0 ? i_reg_wdata[1:0] : cfg0_q; // see RULE_04
			cfg1_q <= wr_cfg1 ? i_reg_wdata[6:2] : cfg1_q; // see RULE_04
		end
	end

	// field decode
	assign filter_code = accel_filter_rate_config_q[7:4];
	assign odr_code = accel_filter_rate_config_q[3:0];
	assign downs_code = downs_q[6:4];
	assign filter_ok = (filter_code == `FILT_FOURFOLD_OVERSAMPLING) || (filter_code == `FILT_TWOFOLD_OVERSAMPLING) ||
		(filter_code == `FILT_NORMAL); // see RULE_01
	assign odr_ok = (odr_code >= `ODR_MIN) && (odr_code <= `ODR_MAX); // see RULE_02
	assign cfg_ok = filter_ok && odr_ok;
	assign stream_mode = !cfg0_q[`CFG0_MODE_BIT]; // see RULE_07
	assign acc_en = cfg1_q[`CFG1_ACC_BIT];
	assign pin_en = {cfg1_q[`CFG1_PIN2_BIT], cfg1_q[`CFG1_PIN1_BIT]};
	assign scale_d = 5'h03 << range_q; // see RULE_03

	// each rate is half the one above it, so one base divider serves all
	assign odr_shift = odr_ok ? 4'(`ODR_MAX - odr_code) : 4'h0; // see RULE_02
	assign fifo_shift = 4'(odr_shift + {1'b0, downs_code}); // see RULE_05
	assign base_tick = (base_cnt_q == 14'(BASE_TICK_CYCLES - 1));
	assign odr_tick = base_tick && cfg_ok && low_bits_clear(rate_cnt_q, odr_shift);
	assign fifo_tick = base_tick && cfg_ok && low_bits_clear(rate_cnt_q, fifo_shift); // see RULE_05

	always_ff @(posedge i_core_clk)
	begin
		if (rst_all)
		begin
			base_cnt_q <= 14'h0000;
			rate_cnt_q <= 15'h0000;
		end
		else
		begin
			base_cnt_q <= base_tick ? 14'h0000 : 14'(base_cnt_q + 1'b1);
			rate_cnt_q <= base_tick ? 15'(rate_cnt_q + 1'b1) : rate_cnt_q;
		end
	end

	// decoded settings and error code, held in flops for the outputs
	always_ff @(posedge i_core_clk)
	begin
		if (rst_all)
		begin
			err_q <= 3'h0;
			four_q <= 1'b0;
			two_q <= 1'b0;
			scale_q <= 5'h06;
			tick_q <= 1'b0;
		end
		else
		begin
			err_q <= cfg_ok ? 3'h0 : `ERR_CONFIG; // see RULE_13
			four_q <= (filter_code == `FILT_FOURFOLD_OVERSAMPLING); // see RULE_01
			two_q <= (filter_code == `FILT_TWOFOLD_OVERSAMPLING); // see RULE_01
			scale_q <= scale_d; // see RULE_03
			tick_q <= odr_tick; // see RULE_02
		end
	end

	// event pins, edge captured per pin
	assign pins = {i_event_pin_two, i_event_pin_one};
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_pin
			assign pin_rise[g] = pins[g] && !pin_prev_q[g];
			// a new edge in the cycle its frame is taken stays pending
			assign evt_pend_d[g] = (pin_rise[g] && pin_en[g]) ||
				(evt_pend_q[g] && !(push_fire && push_frame.kind == frame_kind_t'(g + 1)));
		end
	endgenerate

	// fifo mode keeps a waiting frame and drops later ticks
	assign acc_pend_d = (fifo_tick && acc_en) ||
		(acc_pend_q && !(push_fire && push_frame.kind == KIND_ACCEL)); // see RULE_08

	always_ff @(posedge i_core_clk)
	begin
		if (rst_all)
		begin
			pin_prev_q <= 2'h0;
			evt_pend_q <= 2'h0;
			acc_pend_q <= 1'b0;
			sample_q <= '0;
		end
		else if (flush)
		begin
			pin_prev_q <= pins;
			evt_pend_q <= 2'h0;
			acc_pend_q <= 1'b0;
		end
		else
		begin
			pin_prev_q <= pins;
			evt_pend_q <= evt_pend_d; // see RULE_09, RULE_10
			acc_pend_q <= acc_pend_d; // see RULE_08
			if (fifo_tick && acc_en && !(acc_pend_q && !push_fire))
				sample_q <= i_sample;
		end
	end

	// samples first, then pin one, then pin two
	assign push_valid = acc_pend_q || (|evt_pend_q);
	assign push_frame.kind = acc_pend_q ? KIND_ACCEL :
		evt_pend_q[0] ? KIND_PIN_ONE : KIND_PIN_TWO; // see RULE_09, RULE_10
	assign push_frame.data = acc_pend_q ? sample_q : '0;
	assign push_fire = push_valid && push_ready;

	// stream mode frees the head slot so the newest frame always enters
	assign drop_oldest = stream_mode && fifo_full && push_valid; // see RULE_14
	assign pop_ready = i_frame_ready || drop_oldest; // see RULE_14
	assign pop_fire = pop_valid && pop_ready;

	frame_fifo #(
		.WIDTH($bits(frame_t)),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_rst(rst_all),
		.i_clear(flush),
		.i_in_valid(push_valid),
		.o_in_ready(push_ready),
		.i_in_data(push_frame),
		.o_out_valid(pop_valid),
		.i_out_ready(pop_ready),
		.o_out_data(pop_frame),
		.o_full(fifo_full)
	);

	// byte count moves only on whole frames entering or leaving
	assign bytes_d = 14'(bytes_q + (push_fire ? frame_bytes(push_frame.kind) : 14'h0000)
		- (pop_fire ? frame_bytes(pop_frame.kind) : 14'h0000)); // see RULE_12

	always_ff @(posedge i_core_clk)
	begin
		if (rst_all || flush)
			bytes_q <= 14'h0000;
		else
			bytes_q <= bytes_d; // see RULE_12
	end

	// soft reset lands after a settle delay, like a power-on load
	assign soft_fire = (sr_state_q == SR_WAIT) && (sr_cnt_q == 15'(SOFT_RESET_CYCLES - 1));

	always_comb
	begin
		sr_state_d = sr_state_q;
		unique case (sr_state_q)
			SR_IDLE:
				if (wr_cmd && i_reg_wdata == `CMD_SOFTRESET)
					sr_state_d = SR_WAIT;
			SR_WAIT:
				if (soft_fire)
					sr_state_d = SR_IDLE;
			default:
				sr_state_d = SR_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			sr_state_q <= SR_IDLE;
			sr_cnt_q <= 15'h0000;
		end
		else
		begin
			sr_state_q <= sr_state_d;
			sr_cnt_q <= (sr_state_q == SR_WAIT) ? 15'(sr_cnt_q + 1'b1) : 15'h0000;
		end
	end

	// read mux, unmapped addresses read zero
	assign rdata_d = (i_reg_addr == `ADDR_CHIP_ID) ? CHIP_ID :
		(i_reg_addr == `ADDR_ERR) ? {3'h0, err_q, 2'h0} : // see RULE_13
		(i_reg_addr == `ADDR_FIFO_LEN0) ? bytes_q[7:0] :
		(i_reg_addr == `ADDR_FIFO_LEN1) ? {2'h0, bytes_q[13:8]} :
		(i_reg_addr == `ADDR_ACCEL_FILTER_RATE_CONFIG) ? accel_filter_rate_config_q :
		(i_reg_addr == `ADDR_ACC_RANGE) ? {6'h00, range_q} :
		(i_reg_addr == `ADDR_DOWNS) ? downs_q :
		(i_reg_addr == `ADDR_WTM0) ? wtm_q[7:0] :
		(i_reg_addr == `ADDR_WTM1) ? {3'h0, wtm_q[12:8]} :
		(i_reg_addr == `ADDR_CFG0) ? {6'h00, cfg0_q} :
		(i_reg_addr == `ADDR_CFG1) ? {1'b0, cfg1_q, 2'h0} : 8'h00;

	always_ff @(posedge i_core_clk)
	begin
		if (rst_all)
			rdata_q <= 8'h00;
		else if (i_reg_rd)
			rdata_q <= rdata_d;
	end

	assign o_reg_rdata = rdata_q;
	assign o_sample_tick = tick_q;
	assign o_frame_valid = pop_valid && !drop_oldest;
	assign o_frame = pop_frame;
	assign o_fifo_bytes = bytes_q;
	assign o_fifo_watermark = (bytes_q >= {1'b0, wtm_q}); // see RULE_06
	assign o_fifo_full = fifo_full;
	assign o_config_error = (err_q == `ERR_CONFIG);
	assign o_fourfold_oversampling = four_q;
	assign o_twofold_oversampling = two_q;
	assign o_full_scale_g = scale_q;
endmodule

// ---- accel_config_fifo_setup_regs_asserts.sv ----
`timescale 1ns/1ps
module accel_regs_checker
	import accel_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_reg_wr,
	input wire logic [6:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic o_sample_tick,
	input wire logic o_frame_valid,
	input wire logic [13:0] o_fifo_bytes,
	input wire logic o_fifo_watermark,
	input wire logic o_fifo_full,
	input wire logic o_config_error,
	input wire logic o_fourfold_oversampling,
	input wire logic o_twofold_oversampling,
	input wire logic [4:0] o_full_scale_g
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// shadow of the threshold; a soft reset is not tracked, so zero it before one
	logic [12:0] thr_q;
	wire wr_conf = i_reg_wr && i_reg_addr == 7'h40;
	wire wr_range = i_reg_wr && i_reg_addr == 7'h41;
	wire [3:0] filt = i_reg_wdata[7:4];
	wire [3:0] odr = i_reg_wdata[3:0];
	wire cfg_ok = filt >= 4'h8 && filt <= 4'ha && odr >= 4'h5 && odr <= 4'hc;
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			thr_q <= 13'h0000;
		else if (i_reg_wr && i_reg_addr == 7'h46)
			thr_q[7:0] <= i_reg_wdata;
		else if (i_reg_wr && i_reg_addr == 7'h47)
			thr_q[12:8] <= i_reg_wdata[4:0];
	end
	property p_wm;
		o_fifo_watermark == (o_fifo_bytes >= {1'b0, thr_q});
	endproperty
	a_wm: assert property (p_wm) else $error("watermark disagrees with level");
	property p_cap;
		o_fifo_bytes <= 14'h0038;
	endproperty
	a_cap: assert property (p_cap) else $error("byte count above eight frames");
	property p_empty;
		o_fifo_bytes == 14'h0000 |-> !o_frame_valid && !o_fifo_full;
	endproperty
	a_empty: assert property (p_empty) else $error("frame shown while empty");
	property p_full;
		o_fifo_full |-> o_fifo_bytes >= 14'h0010;
	endproperty
	a_full: assert property (p_full) else $error("full with too few bytes");
	property p_osr;
		wr_conf |-> ##2 o_fourfold_oversampling == ($past(filt, 2) == 4'h8)
			&& o_twofold_oversampling == ($past(filt, 2) == 4'h9);
	endproperty
	a_osr: assert property (p_osr) else $error("oversampling decode wrong");
	property p_err;
		wr_conf |-> ##2 o_config_error == !$past(cfg_ok, 2);
	endproperty
	a_err: assert property (p_err) else $error("config error flag wrong");
	property p_scale;
		wr_range |-> ##2 o_full_scale_g == (5'h03 << $past(i_reg_wdata[1:0], 2));
	endproperty
	a_scale: assert property (p_scale) else $error("full scale decode wrong");
	property p_stop;
		o_config_error [*3] |-> !o_sample_tick;
	endproperty
	a_stop: assert property (p_stop) else $error("tick under bad config");
	property p_rst;
		$fell(i_rst) |-> o_full_scale_g == 5'h06 && !o_config_error && o_fifo_bytes == 14'h0000;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	c_full: cover property (o_fifo_full);
	c_wm: cover property ($rose(o_fifo_watermark));
	c_err: cover property ($rose(o_config_error));
endmodule
bind accel_config_fifo_setup_regs accel_regs_checker chk_i (.i_core_clk, .i_rst, .i_reg_wr,
	.i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_sample_tick, .o_frame_valid, .o_fifo_bytes,
	.o_fifo_watermark, .o_fifo_full, .o_config_error, .o_fourfold_oversampling,
	.o_twofold_oversampling, .o_full_scale_g);

// ---- host_frame_sink.sv ----
`timescale 1ns/1ps
module host_frame_sink
	import accel_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_stall,
	input wire logic i_frame_valid,
	output logic o_frame_ready,
	output logic [7:0] o_taken
);
	logic [7:0] taken_q = 8'h00;
	// the host only withholds ready; stalling is how the fifo gets filled
	assign o_frame_ready = !i_stall;
	assign o_taken = taken_q;
	// counts frames the host really took, so drops and lost ticks show up
	always @(posedge i_core_clk)
	begin
		if (i_frame_valid && o_frame_ready)
			taken_q <= 8'(taken_q + 8'h01);
	end
endmodule

// ---- test_accel_config_fifo_setup_regs.sv ----
`timescale 1ns/1ps
module test_accel_config_fifo_setup_regs;
	import accel_pkg::*;
	logic clk = 0, rst = 1, wr = 0, rd = 0, p1 = 0, p2 = 0, stall = 1;
	logic [6:0] addr = 7'h00;
	logic [7:0] wdata = 8'h00, rdata;
	sample_t samp = '0;
	frame_t frame;
	logic tick, fv, fr, wm, full, err, f4, f2;
	logic [13:0] bytes;
	logic [4:0] scale;
	logic [7:0] taken;
	int err_total = 0, checks = 0;
	always #25 clk = ~clk;
	always @(posedge clk) samp <= samp + 48'h1;
	accel_config_fifo_setup_regs #(.BASE_TICK_CYCLES(8), .SOFT_RESET_CYCLES(4)) uut (
		.i_core_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_sample(samp), .i_event_pin_one(p1),
		.i_event_pin_two(p2), .o_sample_tick(tick), .o_frame_valid(fv), .i_frame_ready(fr),
		.o_frame(frame), .o_fifo_bytes(bytes), .o_fifo_watermark(wm), .o_fifo_full(full),
		.o_config_error(err), .o_fourfold_oversampling(f4), .o_twofold_oversampling(f2),
		.o_full_scale_g(scale));
	host_frame_sink host (.i_core_clk(clk), .i_stall(stall), .i_frame_valid(fv),
		.o_frame_ready(fr), .o_taken(taken));
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr_reg(logic [6:0] a, logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(string n, logic [6:0] a, logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(n, e, rdata);
	endtask
	task automatic wait_bytes(logic [13:0] e);
		for (int i = 0; i < 400 && bytes !== e; i++)
		begin
			@(posedge clk);
			#1;
		end
		chk("bytes", e, bytes);
	endtask
	task automatic pulse(bit two);
		@(posedge clk);
		if (two)
			p2 <= 1'b1;
		else
			p1 <= 1'b1;
		@(posedge clk);
		p1 <= 1'b0;
		p2 <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic ticks(int e);
		int n = 0;
		repeat (20) @(posedge clk);
		repeat (160)
		begin
			@(posedge clk);
			#1 n += tick;
		end
		chk("ticks", e, n);
	endtask
	task automatic t_reset();
		rd_chk("filter_rate", 7'h40, 8'ha8);
		rd_chk("full_scale", 7'h41, 8'h01);
		rd_chk("reduction", 7'h45, 8'h80);
		rd_chk("operating", 7'h48, 8'h02);
		rd_chk("source", 7'h49, 8'h10);
		chk("scale", 16'd6, scale);
	endtask
	task automatic t_conf();
		logic [7:0] cfg [6] = '{8'h8c, 8'h95, 8'hac, 8'hb8, 8'ha4, 8'had};
		logic [2:0] exp [6] = '{3'b100, 3'b010, 3'b000, 3'b001, 3'b001, 3'b001};
		for (int i = 0; i < 6; i++)
		begin
			wr_reg(7'h40, cfg[i]);
			@(posedge clk);
			#1 chk("decode", exp[i], {f4, f2, err});
		end
	endtask
	task automatic t_range();
		for (int r = 0; r < 4; r++)
		begin
			wr_reg(7'h41, 8'(r));
			@(posedge clk);
			#1 chk("scale", 16'd3 << r, scale);
			rd_chk("full_scale", 7'h41, 8'(r));
		end
	endtask
	task automatic t_rate();
		wr_reg(7'h40, 8'hac);
		ticks(20);
		wr_reg(7'h40, 8'hab);
		ticks(10);
		wr_reg(7'h40, 8'ha4);
		ticks(0);
		wr_reg(7'h40, 8'hac);
	endtask
	task automatic t_fifo();
		logic [15:0] head;
		logic [7:0] n0;
		wr_reg(7'h46, 8'h1e);
		wr_reg(7'h47, 8'h00);
		wr_reg(7'h49, 8'h50);
		wait_bytes(14'd56);
		chk("full", 16'h1, full);
		chk("kind", KIND_ACCEL, frame.kind);
		head = frame.data.z;
		repeat (40) @(posedge clk);
		#1 chk("stream_moves", 16'h1, frame.data.z !== head);
		wr_reg(7'h48, 8'h03);
		repeat (2) @(posedge clk);
		#1 head = frame.data.z;
		repeat (40) @(posedge clk);
		#1 chk("fifo_holds", head, frame.data.z);
		chk("valid", 16'h1, fv);
		chk("wm_high", 16'h1, wm);
		wr_reg(7'h49, 8'h10);
		n0 = taken;
		stall <= 1'b0;
		wait_bytes(14'd0);
		chk("taken", 16'd9, 8'(taken - n0));
		chk("wm_low", 16'h0, wm);
		stall <= 1'b1;
	endtask
	task automatic t_events();
		logic [7:0] n0;
		wr_reg(7'h49, 8'h18);
		pulse(1'b1);
		#1 chk("pin_two_off", 16'h0, bytes);
		pulse(1'b0);
		#1 chk("pin_one", 16'h2, bytes);
		chk("kind_one", KIND_PIN_ONE, frame.kind);
		wr_reg(7'h49, 8'h14);
		pulse(1'b1);
		#1 chk("pin_two", 16'h4, bytes);
		@(posedge clk);
		n0 = taken;
		stall <= 1'b0;
		wait_bytes(14'd0);
		chk("events_taken", 16'd2, 8'(taken - n0));
		chk("valid_low", 16'h0, fv);
	endtask
	task automatic t_cmd();
		logic [13:0] b0;
		@(posedge clk);
		stall <= 1'b1;
		wr_reg(7'h49, 8'h50);
		wr_reg(7'h45, 8'h90);
		wr_reg(7'h7e, 8'hb0);
		#1 chk("flush", 16'h0, bytes);
		@(posedge clk);
		#1 b0 = bytes;
		repeat (96) @(posedge clk);
		#1 chk("downsampled", 16'd42, 14'(bytes - b0));
		wr_reg(7'h46, 8'h00);
		wr_reg(7'h47, 8'h00);
		wr_reg(7'h41, 8'h02);
		wr_reg(7'h40, 8'h8b);
		wr_reg(7'h7e, 8'hb6);
		rd_chk("reset_delay", 7'h41, 8'h02);
		repeat (4) @(posedge clk);
		rd_chk("soft_filter_rate", 7'h40, 8'ha8);
		rd_chk("soft_full_scale", 7'h41, 8'h01);
		rd_chk("soft_reduction", 7'h45, 8'h80);
		rd_chk("soft_source", 7'h49, 8'h10);
		chk("soft_scale", 16'd6, scale);
		chk("soft_bytes", 16'h0, bytes);
	endtask
	task automatic final_report();
		if (err_total == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_conf();
		t_range();
		t_rate();
		t_fifo();
		t_events();
		t_cmd();
		final_report();
	end
	initial
	begin
		#2000000;
		err_total++;
		final_report();
	end
endmodule
